// [logic/csbsu_top.sv]
// csbsu_top: slot engine, buffer exchange and status flags of the codec serial interface
// Operation
// - counter steps once per enabled slot
// - any-direction slot steps; only rx slots store
// - buffer length one to four words
// - match clears counter and swaps shadow/holding
// - one interrupt per buffer exchange
// - tx empty set on swap, cleared on write
// - tx underflow on unrefreshed word, write clears
// - tx underflow ignores words beyond length; any hold write clears tx empty
// - rx full until all used words read
// - rx overflow on unread refill, read clears
// - overflow overwrites old holding word
// - rx flags ignore words beyond length
// - status shows frame slot counter
// - word counter not aligned to frames
// - unused slots drive low by default
// - unused slots float in shared mode
// - loopback feeds output into input path
// - underflow sends zeros when repeat off
// - underflow resends last word when repeat on
// - external clock runs in sleep, wakes
// - tx slot loads shadow word, then steps
// - rx slot stores shift word, then steps
// - stop after last slot until sync
// - halt in idle when select set
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module csbsu_top (
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RESET,
  // register port
  input  wire logic [9:0]  REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [15:0] REG_RDATA,
  // serial link
  input  wire logic        BIT_CLOCK_LINE,
  input  wire logic        FRAME_SYNC_LINE,
  input  wire logic        SERIAL_DATA_IN,
  output logic             SERIAL_DATA_OUT,
  output logic             SERIAL_DATA_OUT_OE,
  // processor power state
  input  wire logic        CPU_IDLE,
  input  wire logic        CPU_SLEEP,
  // events
  output logic             BUFFER_IRQ,
  output logic             WAKE_IRQ
);
  csbsu_link_if link ();

  csbsu_front u_front (
    .clk             (CLOCK),
    .rst             (RESET),
    .bit_clock_line  (BIT_CLOCK_LINE),
    .frame_sync_line (FRAME_SYNC_LINE),
    .serial_data_in  (SERIAL_DATA_IN),
    .lnk             (link.front)
  );

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  logic [15:0]                ctrl_one_r;
  logic [15:0]                ctrl_two_r;
  logic [15:0]                tx_enable_r;
  logic [15:0]                rx_enable_r;
  logic [1:0]                 wcnt_r;
  logic [3:0]                 slot_r;
  logic [3:0]                 bit_r;
  csbsu_pkg::csbsu_frame_type frame_r;
  logic [15:0]                tx_shift_r;
  logic [15:0]                rx_shift_r;
  logic                       sdo_r;
  logic                       sdo_oe_r;
  logic                       irq_r;
  logic                       wake_r;
  logic                       tx_empty_r;
  logic [15:0]                rdata_r;
  logic [15:0]                rdata_nxt;
  wire  [15:0]                tx_hold_w   [4];
  wire  [15:0]                tx_shadow_w [4];
  wire  [15:0]                rx_hold_w   [4];
  wire  [3:0]                 tx_wr_hit;
  wire  [3:0]                 rx_rd_hit;
  wire  [3:0]                 in_use;
  wire  [3:0]                 tx_unf_w;
  wire  [3:0]                 rx_new_w;
  wire  [3:0]                 rx_ovf_w;

  function automatic logic hold_hit(input logic [9:0] addr, input logic [9:0] base,
                                    input int idx);
    hold_hit = (addr == base + 10'(idx) * csbsu_pkg::HOLD_STRIDE);
  endfunction : hold_hit

  // control decode
  wire       enable      = ctrl_one_r[csbsu_pkg::C1_ENABLE];
  wire       idle_halt   = ctrl_one_r[csbsu_pkg::C1_IDLE_HALT];
  wire       loopback    = ctrl_one_r[csbsu_pkg::C1_LOOPBACK];
  wire       clk_dir     = ctrl_one_r[csbsu_pkg::C1_CLK_DIR];
  wire       unf_repeat  = ctrl_one_r[csbsu_pkg::C1_UNF_REPEAT];
  wire       idle_out    = ctrl_one_r[csbsu_pkg::C1_IDLE_OUT];
  wire [1:0] buffer_length_sel        = ctrl_two_r[csbsu_pkg::C2_BUFFER_LENGTH_SEL_LO +: 2];
  wire [3:0] flen        = ctrl_two_r[csbsu_pkg::C2_FLEN_LO +: 4];
  // halted in idle when selected, and in sleep unless the bit clock is external
  wire       run         = enable & ~(CPU_IDLE & idle_halt) & ~(CPU_SLEEP & ~clk_dir);
  wire       rise        = link.bclk_rise & run;
  wire       fall        = link.bclk_fall & run;

  // slot engine decode
  wire        active      = (frame_r == csbsu_pkg::FRAME_ACTIVE);
  wire        cur_tx      = tx_enable_r[slot_r];
  wire        cur_rx      = rx_enable_r[slot_r];
  wire        first_bit   = (bit_r == 4'h0);
  wire        last_slot   = (slot_r == flen);
  wire        frame_start = fall & ~active & link.fsync;
  wire        slot_end    = fall & active & (bit_r == csbsu_pkg::LAST_BIT);
  wire        advance     = slot_end & (cur_tx | cur_rx);
  wire        swap        = advance & (wcnt_r == buffer_length_sel);
  wire        rx_store    = slot_end & cur_rx;
  wire        din         = loopback ? sdo_r : link.sdin;
  wire [15:0] rx_word     = {rx_shift_r[14:0], din};
  wire        unf_zero    = tx_unf_w[wcnt_r] & ~unf_repeat;
  wire [15:0] tx_word     = unf_zero ? 16'h0000 : tx_shadow_w[wcnt_r];
  wire        tx_live     = active & cur_tx;
  wire [15:0] tx_src      = first_bit ? tx_word : tx_shift_r;
  wire        tx_bit      = tx_live & tx_src[15];
  wire        tx_drive    = tx_live | ~idle_out;
  wire        tx_msb      = tx_word[15];
  wire        tx_wr_any   = |tx_wr_hit;

  // status flags; the per-word flags are masked to the words in use, tx empty is not
  wire        tx_unf_flag = |(tx_unf_w & in_use);
  wire        rx_full     = |(rx_new_w & in_use);
  wire        rx_ovf_flag = |(rx_ovf_w & in_use);
  wire [15:0] status_w    = (16'(slot_r) << csbsu_pkg::ST_SLOT_LO)
                          | (16'(rx_ovf_flag) << csbsu_pkg::ST_RX_OVF)
                          | (16'(rx_full) << csbsu_pkg::ST_RX_FULL)
                          | (16'(tx_unf_flag) << csbsu_pkg::ST_TX_UNF)
                          | (16'(tx_empty_r) << csbsu_pkg::ST_TX_EMPTY);

  // frame and slot counters; a sync seen mid-frame is ignored
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      frame_r <= csbsu_pkg::FRAME_IDLE;
      slot_r  <= 4'h0;
      bit_r   <= 4'h0;
    end else if (frame_start) begin
      frame_r <= csbsu_pkg::FRAME_ACTIVE;
      slot_r  <= 4'h0;
      bit_r   <= 4'h0;
    end else if (fall && active) begin
      bit_r <= bit_r + 4'h1;
      if (slot_end) begin
        slot_r <= slot_r + 4'h1;
        if (last_slot) frame_r <= csbsu_pkg::FRAME_IDLE;
      end
    end
  end

  sequence frame_last_s;
    slot_end && last_slot;
  endsequence
  frame_stop_a: assert property (frame_last_s |=> !active ##1 !advance)
    else $error("frame did not stop after its last slot");

  // transmit side changes on the rising bit clock edge
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sdo_r      <= 1'b0;
      sdo_oe_r   <= 1'b1;
      tx_shift_r <= 16'h0000;
    end else if (rise) begin
      sdo_r      <= tx_bit;
      sdo_oe_r   <= tx_drive;
      tx_shift_r <= {tx_src[14:0], 1'b0};
    end
  end

  sequence unused_rise_s;
    rise && !tx_live;
  endsequence
  idle_low_a: assert property (unused_rise_s ##0 !idle_out
                               |=> !SERIAL_DATA_OUT && SERIAL_DATA_OUT_OE)
    else $error("unused slot not driven low");
  idle_float_a: assert property (unused_rise_s ##0 idle_out |=> !SERIAL_DATA_OUT_OE)
    else $error("unused slot not released");
  tx_load_a: assert property (rise && tx_live && first_bit
                              |=> SERIAL_DATA_OUT == $past(tx_msb))
    else $error("slot start did not send the shadow word");
  unf_zero_a: assert property (rise && tx_live && first_bit && unf_zero
                               |=> !SERIAL_DATA_OUT)
    else $error("underflowed slot not silent");

  // receive side samples on the falling bit clock edge
  always_ff @(posedge CLOCK) begin
    if (RESET) rx_shift_r <= 16'h0000;
    else if (fall && active) rx_shift_r <= rx_word;
  end

  loop_path_a: assert property (loopback && fall && active
                                |=> rx_shift_r[0] == $past(sdo_r))
    else $error("loopback input not taken from output");

  // word counter runs across frame boundaries
  always_ff @(posedge CLOCK) begin
    if (RESET) wcnt_r <= 2'h0;
    else if (swap) wcnt_r <= 2'h0;
    else if (advance) wcnt_r <= wcnt_r + 2'h1;
  end

  counter_step_a: assert property (advance && !swap |=> wcnt_r == $past(wcnt_r) + 2'h1)
    else $error("word counter did not step by one");
  swap_irq_a: assert property (swap |=> wcnt_r == 2'h0 && BUFFER_IRQ ##1 !BUFFER_IRQ)
    else $error("exchange did not clear counter or pulse interrupt");

  // exchange events
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      irq_r      <= 1'b0;
      wake_r     <= 1'b0;
      tx_empty_r <= 1'b0;
    end else begin
      irq_r      <= swap;
      wake_r     <= swap & CPU_SLEEP & clk_dir;
      tx_empty_r <= swap | (tx_empty_r & ~tx_wr_any);
    end
  end

  empty_flag_a: assert property (swap |=> tx_empty_r)
    else $error("tx empty not set on exchange");
  empty_clear_a: assert property (tx_wr_any && !swap |=> !tx_empty_r)
    else $error("tx empty not cleared by write");

  // per-word holding, shadow and flag state
  for (genvar i = 0; i < csbsu_pkg::NWORDS; i++) begin : g_loc
    logic [15:0] tx_hold_r;
    logic [15:0] tx_shadow_r;
    logic [15:0] rx_hold_r;
    logic [15:0] rx_shadow_r;
    logic        tx_written_r;
    logic        tx_unf_r;
    logic        rx_new_r;
    logic        rx_ovf_r;
    wire         here      = (wcnt_r == 2'(i));
    wire  [15:0] rx_fresh  = (rx_store && here) ? rx_word : rx_shadow_r;
    wire         unf_set   = swap & in_use[i] & ~tx_written_r;
    wire         new_set   = swap & in_use[i];
    wire         ovf_set   = new_set & rx_new_r & ~rx_rd_hit[i];

    assign tx_wr_hit[i]   = REG_WR && hold_hit(REG_ADDR, csbsu_pkg::ADDR_TX_HOLD0, i);
    assign rx_rd_hit[i]   = REG_RD && hold_hit(REG_ADDR, csbsu_pkg::ADDR_RX_HOLD0, i);
    assign in_use[i]      = (2'(i) <= buffer_length_sel);
    assign tx_hold_w[i]   = tx_hold_r;
    assign tx_shadow_w[i] = tx_shadow_r;
    assign rx_hold_w[i]   = rx_hold_r;
    assign tx_unf_w[i]    = tx_unf_r;
    assign rx_new_w[i]    = rx_new_r;
    assign rx_ovf_w[i]    = rx_ovf_r;

    always_ff @(posedge CLOCK) begin
      if (RESET) begin
        tx_hold_r    <= csbsu_pkg::REG_RESET;
        tx_shadow_r  <= 16'h0000;
        rx_hold_r    <= csbsu_pkg::REG_RESET;
        rx_shadow_r  <= 16'h0000;
        tx_written_r <= 1'b0;
        tx_unf_r     <= 1'b0;
        rx_new_r     <= 1'b0;
        rx_ovf_r     <= 1'b0;
      end else begin
        if (tx_wr_hit[i]) tx_hold_r <= REG_WDATA;
        if (swap) tx_shadow_r <= tx_hold_r;
        if (rx_store && here) rx_shadow_r <= rx_word;
        if (swap) rx_hold_r <= rx_fresh;
        tx_written_r <= tx_wr_hit[i] | (tx_written_r & ~swap);
        tx_unf_r     <= unf_set | (tx_unf_r & ~tx_wr_hit[i]);
        rx_new_r     <= new_set | (rx_new_r & ~rx_rd_hit[i]);
        rx_ovf_r     <= ovf_set | (rx_ovf_r & ~rx_rd_hit[i]);
      end
    end
  end

  unf_set_a: assert property (swap && in_use[0] && !g_loc[0].tx_written_r
                              |=> tx_unf_w[0] && tx_unf_flag)
    else $error("unrefreshed tx word not flagged");
  ovf_set_a: assert property (swap && in_use[1] && rx_new_w[1] && !rx_rd_hit[1]
                              |=> rx_ovf_w[1] && rx_ovf_flag)
    else $error("unread rx word refill not flagged");
  rx_over_a: assert property (swap && !(rx_store && wcnt_r == 2'h2)
                              |=> rx_hold_w[2] == $past(g_loc[2].rx_shadow_r))
    else $error("rx holding word not refilled from shadow");
  unused_mask_a: assert property (swap && !in_use[2] |=> !$rose(rx_new_w[2]))
    else $error("word beyond length marked full");

  // register writes
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ctrl_one_r  <= csbsu_pkg::REG_RESET;
      ctrl_two_r  <= csbsu_pkg::REG_RESET;
      tx_enable_r <= csbsu_pkg::REG_RESET;
      rx_enable_r <= csbsu_pkg::REG_RESET;
    end else if (REG_WR) begin
      case (REG_ADDR)
        csbsu_pkg::ADDR_CTRL_ONE:  ctrl_one_r  <= REG_WDATA & csbsu_pkg::C1_MASK;
        csbsu_pkg::ADDR_CTRL_TWO:  ctrl_two_r  <= REG_WDATA & csbsu_pkg::C2_MASK;
        csbsu_pkg::ADDR_TX_ENABLE: tx_enable_r <= REG_WDATA;
        csbsu_pkg::ADDR_RX_ENABLE: rx_enable_r <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // register reads; unmapped addresses read zero
  always_comb begin
    rdata_nxt = 16'h0000;
    case (REG_ADDR)
      csbsu_pkg::ADDR_CTRL_ONE:  rdata_nxt = ctrl_one_r;
      csbsu_pkg::ADDR_CTRL_TWO:  rdata_nxt = ctrl_two_r;
      csbsu_pkg::ADDR_STATUS:    rdata_nxt = status_w;
      csbsu_pkg::ADDR_TX_ENABLE: rdata_nxt = tx_enable_r;
      csbsu_pkg::ADDR_RX_ENABLE: rdata_nxt = rx_enable_r;
      default: begin
        for (int k = 0; k < csbsu_pkg::NWORDS; k++) begin
          if (hold_hit(REG_ADDR, csbsu_pkg::ADDR_RX_HOLD0, k)) rdata_nxt = rx_hold_w[k];
          if (hold_hit(REG_ADDR, csbsu_pkg::ADDR_TX_HOLD0, k)) rdata_nxt = tx_hold_w[k];
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) rdata_r <= 16'h0000;
    else rdata_r <= REG_RD ? rdata_nxt : 16'h0000;
  end

  assign REG_RDATA          = rdata_r;
  assign SERIAL_DATA_OUT    = sdo_r;
  assign SERIAL_DATA_OUT_OE = sdo_oe_r;
  assign BUFFER_IRQ         = irq_r;
  assign WAKE_IRQ           = wake_r;
endmodule : csbsu_top
`default_nettype wire

// [inc/csbsu_pkg.sv]
// csbsu_pkg: constants and types of the codec slot buffer status unit
package csbsu_pkg;
  localparam int          ADDR_W         = 10;
  localparam int          DATA_W         = 16;
  localparam int          NWORDS         = 4;
  // register byte addresses
  localparam logic [9:0]  ADDR_CTRL_ONE  = 10'h240;
  localparam logic [9:0]  ADDR_CTRL_TWO  = 10'h242;
  localparam logic [9:0]  ADDR_STATUS    = 10'h246;
  localparam logic [9:0]  ADDR_TX_ENABLE = 10'h248;
  localparam logic [9:0]  ADDR_RX_ENABLE = 10'h24C;
  localparam logic [9:0]  ADDR_RX_HOLD0  = 10'h250;
  localparam logic [9:0]  ADDR_TX_HOLD0  = 10'h258;
  localparam logic [9:0]  HOLD_STRIDE    = 10'h002;
  // interface_control_one fields
  localparam int          C1_ENABLE      = 15;
  localparam int          C1_IDLE_HALT   = 13;
  localparam int          C1_LOOPBACK    = 11;
  localparam int          C1_CLK_DIR     = 10;
  localparam int          C1_UNF_REPEAT  = 7;
  localparam int          C1_IDLE_OUT    = 6;
  localparam logic [15:0] C1_MASK        = 16'hACC0;
  // interface_control_two fields
  localparam int          C2_BUFFER_LENGTH_SEL_LO     = 10;
  localparam int          C2_FLEN_LO     = 5;
  localparam logic [15:0] C2_MASK        = 16'h0DE0;
  // interface_status_reg fields
  localparam int          ST_SLOT_LO     = 8;
  localparam int          ST_RX_OVF      = 3;
  localparam int          ST_RX_FULL     = 2;
  localparam int          ST_TX_UNF      = 1;
  localparam int          ST_TX_EMPTY    = 0;
  // reset values and slot timing
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [3:0]  LAST_BIT       = 4'hF;

  typedef enum logic {FRAME_IDLE, FRAME_ACTIVE} csbsu_frame_type;
endpackage : csbsu_pkg

// [inc/csbsu_link_if.sv]
// csbsu_link_if: synchronised link events from the front end to the core
`timescale 1ns/1ps
`default_nettype none
interface csbsu_link_if;
  logic bclk_rise;
  logic bclk_fall;
  logic fsync;
  logic sdin;
  modport front (output bclk_rise, output bclk_fall, output fsync, output sdin);
  modport core  (input bclk_rise, input bclk_fall, input fsync, input sdin);
endinterface : csbsu_link_if
`default_nettype wire

// [logic/csbsu_front.sv]
// csbsu_front: synchronisers and bit clock edge detection for the serial link
`timescale 1ns/1ps
`default_nettype none
module csbsu_front (
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // raw link pins
  input  wire logic   bit_clock_line,
  input  wire logic   frame_sync_line,
  input  wire logic   serial_data_in,
  // events to the core
  csbsu_link_if.front lnk
);
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic       bclk_d_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r   <= 3'h0;
      sync_r   <= 3'h0;
      bclk_d_r <= 1'b0;
    end else begin
      meta_r   <= {serial_data_in, frame_sync_line, bit_clock_line};
      sync_r   <= meta_r;
      bclk_d_r <= sync_r[0];
    end
  end

  // edges are found on the second stage only
  assign lnk.bclk_rise = sync_r[0] & ~bclk_d_r;
  assign lnk.bclk_fall = ~sync_r[0] & bclk_d_r;
  assign lnk.fsync     = sync_r[1];
  assign lnk.sdin      = sync_r[2];
endmodule : csbsu_front
`default_nettype wire

// [bench/csbsu_codec_model.sv]
// csbsu_codec_model: codec on the slot bus, makes bit clock and sync, sends and captures words
`timescale 1ns/1ps
`default_nettype none
module csbsu_codec_model (
  // link pins driven by the codec
  output var logic bit_clock_line,
  output var logic frame_sync_line,
  output var logic serial_data_in,
  // link pins watched by the codec
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  logic [15:0] cap [4];
  logic        cap_oe [4];

  // bit clock stands still low between frames
  initial begin
    bit_clock_line  = 1'b0;
    frame_sync_line = 1'b0;
    serial_data_in  = 1'b0;
  end

  // one frame of ns 16-bit slots; word of slot s in frame f is 0xC000 | f<<4 | s
  task automatic run_frame(input logic [3:0] f, input int ns);
    logic [15:0] w;
    frame_sync_line = 1'b1;
    #40 bit_clock_line = 1'b1;
    #40 bit_clock_line = 1'b0;
    for (int s = 0; s < ns; s++) begin
      w = 16'hC000 | {8'h00, f, s[3:0]};
      for (int b = 15; b >= 0; b--) begin
        #40 bit_clock_line = 1'b1;
        frame_sync_line = 1'b0;
        serial_data_in = w[b];
        #40 bit_clock_line = 1'b0;
        cap[s][b] = sdo;
        cap_oe[s] = sdo_oe;
      end
    end
    // released data line: no pull, so show the inverse of the last bit
    #40 serial_data_in = ~serial_data_in;
  endtask : run_frame
endmodule : csbsu_codec_model
`default_nettype wire

// [bench/tb.sv]
// tb: self-checking bench of the codec slot buffer status unit
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock;
  logic        reset;
  logic [9:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        bclk;
  logic        fsync;
  logic        sdin;
  logic        sdout;
  logic        sdout_oe;
  logic        cpu_idle;
  logic        cpu_sleep;
  logic        buffer_irq;
  logic        wake_irq;
  logic [15:0] n_irq;
  logic [15:0] n_wake;
  int          n_fail;
  int          n_compared;
  int          cycles;
  logic [41:0] rows [7];

  csbsu_top dut_u (
    .CLOCK(clock), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .BIT_CLOCK_LINE(bclk), .FRAME_SYNC_LINE(fsync), .SERIAL_DATA_IN(sdin),
    .SERIAL_DATA_OUT(sdout), .SERIAL_DATA_OUT_OE(sdout_oe),
    .CPU_IDLE(cpu_idle), .CPU_SLEEP(cpu_sleep),
    .BUFFER_IRQ(buffer_irq), .WAKE_IRQ(wake_irq)
  );

  csbsu_codec_model codec_u (
    .bit_clock_line(bclk), .frame_sync_line(fsync), .serial_data_in(sdin),
    .sdo(sdout), .sdo_oe(sdout_oe)
  );

  always #2.5 clock = ~clock;

  // interrupt pulses are one cycle long, so count them on every edge
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (reset === 1'b1) begin
      n_irq  <= 16'h0000;
      n_wake <= 16'h0000;
    end else begin
      n_irq  <= n_irq + {15'h0000, buffer_irq === 1'b1};
      n_wake <= n_wake + {15'h0000, wake_irq === 1'b1};
    end
    if (cycles == 20000) begin
      n_fail = n_fail + 1;
      wrap_up();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [9:0] a, input logic [15:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  // run a frame, check the words the codec saw and the status afterwards
  task frame(input logic [3:0] f, input int ns, input logic [15:0] e0, input logic [15:0] e1,
             input logic oe2, input logic [15:0] st);
    @(posedge clock);
    #1 codec_u.run_frame(f, ns);
    repeat (12) @(posedge clock);
    chk(codec_u.cap[0], e0);
    chk(codec_u.cap[1], e1);
    chk({15'h0000, codec_u.cap_oe[0]}, 16'h0001);
    if (ns == 3) begin
      chk({15'h0000, codec_u.cap_oe[2]}, {15'h0000, oe2});
      if (oe2)
        chk(codec_u.cap[2], 16'h0000);
    end
    rd(csbsu_pkg::ADDR_STATUS, st);
    $display("frame %0d done", f);
  endtask : frame

  task wrap_up;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  initial begin
    clock = 1'b0; reset = 1'b1; reg_addr = 10'h000; reg_wdata = 16'h0000;
    reg_wr = 1'b0; reg_rd = 1'b0; cpu_idle = 1'b0; cpu_sleep = 1'b0;
    n_fail = 0; n_compared = 0; cycles = 0;
    rows = '{{csbsu_pkg::ADDR_STATUS, 16'hFFFF, 16'h0000},
             {csbsu_pkg::ADDR_CTRL_ONE, 16'hFFFF, 16'hACC0},
             {csbsu_pkg::ADDR_CTRL_TWO, 16'hFFFF, 16'h0DE0},
             {csbsu_pkg::ADDR_TX_ENABLE, 16'hA5A5, 16'hA5A5},
             {csbsu_pkg::ADDR_RX_ENABLE, 16'h5A5A, 16'h5A5A},
             {csbsu_pkg::ADDR_RX_HOLD0, 16'hFFFF, 16'h0000},
             {10'h244, 16'hFFFF, 16'h0000}};
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1 chk({14'h0000, sdout, sdout_oe}, 16'h0001);
    for (int i = 0; i < 7; i++) begin
      wr(rows[i][41:32], rows[i][31:16]);
      rd(rows[i][41:32], rows[i][15:0]);
    end
    $display("register rows done");
    // two-word buffer, two-slot frame, tx on slots 0 and 1, rx on slot 0 only
    wr(csbsu_pkg::ADDR_CTRL_ONE, 16'h8400);
    wr(csbsu_pkg::ADDR_CTRL_TWO, 16'h0420);
    wr(csbsu_pkg::ADDR_TX_ENABLE, 16'h0003);
    wr(csbsu_pkg::ADDR_RX_ENABLE, 16'h0001);
    wr(csbsu_pkg::ADDR_TX_HOLD0, 16'h1234);
    wr(csbsu_pkg::ADDR_TX_HOLD0 + 10'h002, 16'h5678);
    frame(4'h1, 2, 16'h0000, 16'h0000, 1'b1, 16'h0205);
    rd(csbsu_pkg::ADDR_RX_HOLD0, 16'hC010);
    rd(csbsu_pkg::ADDR_RX_HOLD0 + 10'h002, 16'h0000);
    rd(csbsu_pkg::ADDR_STATUS, 16'h0201);
    frame(4'h2, 2, 16'h1234, 16'h5678, 1'b1, 16'h0207);
    // third slot used by neither direction; block must keep running while idle
    wr(csbsu_pkg::ADDR_CTRL_TWO, 16'h0440);
    cpu_idle <= 1'b1;
    frame(4'h3, 3, 16'h0000, 16'h0000, 1'b1, 16'h030F);
    cpu_idle <= 1'b0;
    rd(csbsu_pkg::ADDR_RX_HOLD0, 16'hC030);
    rd(csbsu_pkg::ADDR_STATUS, 16'h030F);
    rd(csbsu_pkg::ADDR_RX_HOLD0 + 10'h002, 16'h0000);
    rd(csbsu_pkg::ADDR_STATUS, 16'h0303);
    // repeat, shared idle output and loopback, processor asleep with external clock
    wr(csbsu_pkg::ADDR_CTRL_ONE, 16'h8CC0);
    cpu_sleep <= 1'b1;
    frame(4'h4, 3, 16'h1234, 16'h5678, 1'b0, 16'h0307);
    cpu_sleep <= 1'b0;
    rd(csbsu_pkg::ADDR_RX_HOLD0, 16'h1234);
    wr(csbsu_pkg::ADDR_TX_HOLD0, 16'h9ABC);
    rd(csbsu_pkg::ADDR_STATUS, 16'h0306);
    wr(csbsu_pkg::ADDR_TX_HOLD0 + 10'h002, 16'hDEF0);
    rd(csbsu_pkg::ADDR_STATUS, 16'h0304);
    rd(csbsu_pkg::ADDR_RX_HOLD0 + 10'h002, 16'h0000);
    rd(csbsu_pkg::ADDR_STATUS, 16'h0300);
    // halted in idle: a whole frame must pass unseen
    wr(csbsu_pkg::ADDR_CTRL_ONE, 16'hA400);
    cpu_idle <= 1'b1;
    @(posedge clock);
    #1 codec_u.run_frame(4'h5, 2);
    repeat (12) @(posedge clock);
    cpu_idle <= 1'b0;
    rd(csbsu_pkg::ADDR_STATUS, 16'h0300);
    chk(n_irq, 16'h0004);
    chk(n_wake, 16'h0001);
    $display("link tests done");
    // reset in mid-run clears slot index, flags and holding words
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(csbsu_pkg::ADDR_STATUS, 16'h0000);
    rd(csbsu_pkg::ADDR_TX_HOLD0, 16'h0000);
    $display("reset test done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
